// >>> rtl/rqc_pkg.sv
// Constants and types for the receive queue command block
// Behaviour
// - Status bit 12 flags an interrupt caused by queue dwell time over threshold.
// - Status bit 11 flags an interrupt caused by buffered bytes over threshold.
// - Status bit 10 flags an interrupt caused by buffered frames over threshold.
// - Threshold status bits refresh when the host writes one to interrupt bit 13.
// - Bit 9 adds two pad bytes ahead of each frame; resets to zero.
// - Enable bit 7 raises the receive interrupt on dwell time over threshold.
// - Enable bit 6 raises the receive interrupt on byte count over threshold.
// - Enable bit 5 raises the receive interrupt on frame count over threshold.
// - Bit 4 advances the read pointer after the host fully reads a frame.
// - Bit 3 steers strobed accesses, except those to this register, to the queues, ignoring address and byte enables.
// - While bit 3 is set, all other registers are blocked.
// - Writing one to bit 0 frees the errored frame; clears itself when freed.
package rqc_pkg;
   localparam int          ADDR_W        = 11;
   localparam int          DATA_W        = 16;
   localparam logic [10:0] CMD_OFFSET    = 11'h182;
   localparam logic [15:0] CMD_RESET     = 16'h0000;
   localparam int          BIT_DUR_HIT   = 12;
   localparam int          BIT_BC_HIT    = 11;
   localparam int          BIT_FC_HIT    = 10;
   localparam int          BIT_IP_PAD    = 9;
   localparam int          BIT_DUR_EN    = 7;
   localparam int          BIT_BC_EN     = 6;
   localparam int          BIT_FC_EN     = 5;
   localparam int          BIT_AUTO_DQ   = 4;
   localparam int          BIT_DMA       = 3;
   localparam int          BIT_REL       = 0;
   localparam int          THR_DUR       = 2;
   localparam int          THR_BC        = 1;
   localparam int          THR_FC        = 0;
   localparam int          SYNC_STAGES   = 2;

   typedef enum logic [1:0] {
      SRC_CMD,
      SRC_RXQ,
      SRC_REG
   } rqc_src_t;
endpackage : rqc_pkg

// >>> rtl/rqc_thr_if.sv
// Threshold counts in and hit flags out between command block and threshold unit
interface rqc_thr_if #(parameter int CNT_W = 16);
   logic [CNT_W-1:0] frame_count;
   logic [CNT_W-1:0] byte_count;
   logic [CNT_W-1:0] dur_thr;
   logic [CNT_W-1:0] bc_thr;
   logic [CNT_W-1:0] fc_thr;
   logic [2:0]       hit;
   modport ctl (output frame_count, byte_count, dur_thr, bc_thr, fc_thr, input hit);
   modport thr (input frame_count, byte_count, dur_thr, bc_thr, fc_thr, output hit);
endinterface : rqc_thr_if

// >>> rtl/rqc_thr.sv
// Receive threshold evaluation: dwell timer and three compare flags
module rqc_thr #(
   parameter int CNT_W = 16
) (
   input  wire logic core_clk_in,   // Core clock
   input  wire logic reset_n_in,    // Synchronous reset, low
   input  wire logic ce_in,         // Clock enable
   rqc_thr_if.thr    tb             // Counts in, hits out
);
   logic [CNT_W-1:0] dwell_r;
   logic             queue_busy;

   function automatic logic exceeds(input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] thr);
      exceeds = cnt > thr;
   endfunction : exceeds

   assign queue_busy = tb.frame_count != '0;

   // Dwell counts clock cycles from first queued frame; saturates rather than wraps
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         dwell_r <= '0;
      end else if (ce_in) begin
         if (!queue_busy) begin
            dwell_r <= '0;
         end else if (dwell_r != '1) begin
            dwell_r <= dwell_r + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         tb.hit <= 3'h0;
      end else if (ce_in) begin
         tb.hit[rqc_pkg::THR_DUR] <= queue_busy && exceeds(dwell_r, tb.dur_thr);
         tb.hit[rqc_pkg::THR_BC]  <= exceeds(tb.byte_count, tb.bc_thr);
         tb.hit[rqc_pkg::THR_FC]  <= exceeds(tb.frame_count, tb.fc_thr);
      end
   end
endmodule : rqc_thr

// >>> rtl/rqc_cmd.sv
// Receive queue command register with host strobe decode and queue steering
module rqc_cmd #(
   parameter int CNT_W = 16
) (
   input  wire logic                      core_clk_in,                      // Core clock
   input  wire logic                      reset_n_in,                       // Sync reset, low
   input  wire logic                      ce_in,                            // Clock enable
   input  wire logic                      host_address_enable_strobe_n_in,  // Address strobe
   input  wire logic                      host_read_strobe_n_in,            // Read strobe
   input  wire logic                      host_write_strobe_n_in,           // Write strobe
   input  wire logic [rqc_pkg::ADDR_W-1:0] host_addr_in,                    // Byte address
   input  wire logic [1:0]                host_byte_en_n_in,                // Byte enables
   input  wire logic [rqc_pkg::DATA_W-1:0] host_data_in,                    // Write data
   input  wire logic [CNT_W-1:0]          rx_frame_count_in,                // Queued frames
   input  wire logic [CNT_W-1:0]          rx_byte_count_in,                 // Queued bytes
   input  wire logic [CNT_W-1:0]          duration_threshold_value_in,      // Dwell limit
   input  wire logic [CNT_W-1:0]          byte_count_threshold_value_in,    // Byte limit
   input  wire logic [CNT_W-1:0]          frame_count_threshold_value_in,   // Frame limit
   input  wire logic                      isr_refresh_in,                   // Bit 13 write
   input  wire logic                      frame_read_done_in,               // Frame drained
   input  wire logic                      release_done_in,                  // Frame freed
   input  wire logic [rqc_pkg::DATA_W-1:0] rxq_read_data_in,                // Queue data
   input  wire logic [rqc_pkg::DATA_W-1:0] reg_read_data_in,                // Register data
   output logic [rqc_pkg::DATA_W-1:0]     host_data_out,                    // Read data
   output logic                           host_data_oe_out,                 // Bus drive
   output logic                           ip_align_pad_enable_out,          // Two-byte pad
   output logic                           dma_active_out,                   // Window open
   output logic                           rx_irq_out,                       // Rx interrupt
   output logic                           dequeue_pulse_out,                // Next frame
   output logic                           release_pulse_out,                // Free frame
   output logic                           rxq_read_pulse_out,               // Queue read
   output logic                           txq_write_pulse_out,              // Queue write
   output logic [rqc_pkg::DATA_W-1:0]     txq_write_data_out,               // Queue data
   output logic                           reg_read_pulse_out,               // Reg read
   output logic                           reg_write_pulse_out,              // Reg write
   output logic [rqc_pkg::ADDR_W-1:0]     reg_addr_out,                     // Reg address
   output logic [rqc_pkg::DATA_W-1:0]     reg_write_data_out,               // Reg data
   output logic [1:0]                     reg_byte_en_n_out                 // Reg enables
);
   logic                         aen_s1, aen_s2;
   logic                         rd_s1, rd_s2, rd_s3;
   logic                         wr_s1, wr_s2, wr_s3;
   logic [rqc_pkg::ADDR_W-1:0]   addr_s1, addr_s2, addr_q;
   logic [1:0]                   be_s1, be_s2, be_q;
   logic [rqc_pkg::DATA_W-1:0]   dat_s1, dat_s2, dat_q;
   logic                         rd_start, wr_done, cmd_hit;
   logic                         wr_lo, wr_hi, rel_set;
   logic [2:0]                   thr_en_r;
   logic [2:0]                   stat_r;
   logic                         auto_dq_r;
   logic                         rel_r;
   logic                         rd_pend_r;
   rqc_pkg::rqc_src_t            rd_src_r;
   logic [rqc_pkg::DATA_W-1:0]   cmd_value;

   rqc_thr_if #(.CNT_W(CNT_W)) thr_bus ();

   assign thr_bus.frame_count = rx_frame_count_in;
   assign thr_bus.byte_count  = rx_byte_count_in;
   assign thr_bus.dur_thr     = duration_threshold_value_in;
   assign thr_bus.bc_thr      = byte_count_threshold_value_in;
   assign thr_bus.fc_thr      = frame_count_threshold_value_in;

   rqc_thr #(.CNT_W(CNT_W)) u_thr (
      .core_clk_in (core_clk_in),
      .reset_n_in  (reset_n_in),
      .ce_in       (ce_in),
      .tb          (thr_bus.thr)
   );

   // Host pins are asynchronous to the core clock
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         aen_s1  <= 1'b1;
         aen_s2  <= 1'b1;
         rd_s1   <= 1'b1;
         rd_s2   <= 1'b1;
         rd_s3   <= 1'b1;
         wr_s1   <= 1'b1;
         wr_s2   <= 1'b1;
         wr_s3   <= 1'b1;
         addr_s1 <= '0;
         addr_s2 <= '0;
         be_s1   <= 2'h3;
         be_s2   <= 2'h3;
         dat_s1  <= '0;
         dat_s2  <= '0;
      end else if (ce_in) begin
         aen_s1  <= host_address_enable_strobe_n_in;
         aen_s2  <= aen_s1;
         rd_s1   <= host_read_strobe_n_in;
         rd_s2   <= rd_s1;
         rd_s3   <= rd_s2;
         wr_s1   <= host_write_strobe_n_in;
         wr_s2   <= wr_s1;
         wr_s3   <= wr_s2;
         addr_s1 <= host_addr_in;
         addr_s2 <= addr_s1;
         be_s1   <= host_byte_en_n_in;
         be_s2   <= be_s1;
         dat_s1  <= host_data_in;
         dat_s2  <= dat_s1;
      end
   end

   // One more stage so write data is taken from while the strobe was still low
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         addr_q <= '0;
         be_q   <= 2'h3;
         dat_q  <= '0;
      end else if (ce_in) begin
         addr_q <= addr_s2;
         be_q   <= be_s2;
         dat_q  <= dat_s2;
      end
   end

   assign rd_start = !aen_s2 && !rd_s2 && rd_s3;
   assign wr_done  = !aen_s2 && wr_s2 && !wr_s3;
   // Low address bit dropped: either byte of the word selects the register
   assign cmd_hit  = addr_q[rqc_pkg::ADDR_W-1:1] == rqc_pkg::CMD_OFFSET[rqc_pkg::ADDR_W-1:1];
   assign wr_lo    = wr_done && cmd_hit && !be_q[0];
   assign wr_hi    = wr_done && cmd_hit && !be_q[1];
   assign rel_set  = wr_lo && dat_q[rqc_pkg::BIT_REL];

   // Threshold enables and auto dequeue; status and reserved bits have no write path
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         thr_en_r  <= rqc_pkg::CMD_RESET[rqc_pkg::BIT_DUR_EN:rqc_pkg::BIT_FC_EN];
         auto_dq_r <= rqc_pkg::CMD_RESET[rqc_pkg::BIT_AUTO_DQ];
      end else if (ce_in && wr_lo) begin
         thr_en_r  <= dat_q[rqc_pkg::BIT_DUR_EN:rqc_pkg::BIT_FC_EN];
         auto_dq_r <= dat_q[rqc_pkg::BIT_AUTO_DQ];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         ip_align_pad_enable_out <= rqc_pkg::CMD_RESET[rqc_pkg::BIT_IP_PAD];
      end else if (ce_in && wr_hi) begin
         ip_align_pad_enable_out <= dat_q[rqc_pkg::BIT_IP_PAD];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         dma_active_out <= rqc_pkg::CMD_RESET[rqc_pkg::BIT_DMA];
      end else if (ce_in && wr_lo) begin
         dma_active_out <= dat_q[rqc_pkg::BIT_DMA];
      end
   end

   // Setting wins over a release completing in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         rel_r             <= rqc_pkg::CMD_RESET[rqc_pkg::BIT_REL];
         release_pulse_out <= 1'b0;
      end else if (ce_in) begin
         release_pulse_out <= rel_set;
         if (rel_set) begin
            rel_r <= 1'b1;
         end else if (release_done_in) begin
            rel_r <= 1'b0;
         end
      end
   end

   // Cause flags are snapshots; they hold until the next refresh
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         stat_r <= 3'h0;
      end else if (ce_in && isr_refresh_in) begin
         stat_r <= thr_en_r & thr_bus.hit;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         rx_irq_out <= 1'b0;
      end else if (ce_in) begin
         rx_irq_out <= |(thr_en_r & thr_bus.hit);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         dequeue_pulse_out <= 1'b0;
      end else if (ce_in) begin
         dequeue_pulse_out <= auto_dq_r && frame_read_done_in;
      end
   end

   // Write steering: command register always, else queue in the window, else registers
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         txq_write_pulse_out <= 1'b0;
         txq_write_data_out  <= '0;
         reg_write_pulse_out <= 1'b0;
         reg_write_data_out  <= '0;
         reg_byte_en_n_out   <= 2'h3;
      end else if (ce_in) begin
         txq_write_pulse_out <= wr_done && !cmd_hit && dma_active_out;
         reg_write_pulse_out <= wr_done && !cmd_hit && !dma_active_out;
         if (wr_done && !cmd_hit) begin
            txq_write_data_out <= dat_q;
            reg_write_data_out <= dat_q;
            reg_byte_en_n_out  <= be_q;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         reg_addr_out <= '0;
      end else if (ce_in && (rd_start || wr_done) && !cmd_hit && !dma_active_out) begin
         reg_addr_out <= addr_q;
      end
   end

   // Read request cycle picks the source; data follows one cycle later
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         rd_pend_r          <= 1'b0;
         rd_src_r           <= rqc_pkg::SRC_CMD;
         rxq_read_pulse_out <= 1'b0;
         reg_read_pulse_out <= 1'b0;
      end else if (ce_in) begin
         rd_pend_r          <= rd_start;
         rxq_read_pulse_out <= rd_start && !cmd_hit && dma_active_out;
         reg_read_pulse_out <= rd_start && !cmd_hit && !dma_active_out;
         if (rd_start) begin
            case (1'b1)
               cmd_hit:        rd_src_r <= rqc_pkg::SRC_CMD;
               dma_active_out: rd_src_r <= rqc_pkg::SRC_RXQ;
               default:        rd_src_r <= rqc_pkg::SRC_REG;
            endcase
         end
      end
   end

   // DMA bit 3 is write-only and reads back zero like the reserved bits
   assign cmd_value = {3'h0, stat_r, ip_align_pad_enable_out, 1'b0, thr_en_r,
                       auto_dq_r, 3'h0, rel_r};

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         host_data_out <= '0;
      end else if (ce_in && rd_pend_r) begin
         case (rd_src_r)
            rqc_pkg::SRC_CMD: host_data_out <= cmd_value;
            rqc_pkg::SRC_RXQ: host_data_out <= rxq_read_data_in;
            rqc_pkg::SRC_REG: host_data_out <= reg_read_data_in;
            default:          host_data_out <= '0;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         host_data_oe_out <= 1'b0;
      end else if (ce_in) begin
         host_data_oe_out <= !aen_s2 && !rd_s2;
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   sequence s_window_read;
      ce_in && rd_start && !cmd_hit && dma_active_out;
   endsequence

   // Completion only clears when no new request lands in the same cycle
   sequence s_release_cycle;
      ce_in && rel_r && !rel_set ##0 release_done_in;
   endsequence

   AST_DUR_CAUSE: assert property (
      ce_in && isr_refresh_in && thr_en_r[2] && thr_bus.hit[2] |=> stat_r[2])
      else $error("dwell cause flag not set");
   AST_BC_CAUSE: assert property (
      ce_in && isr_refresh_in && thr_en_r[1] && thr_bus.hit[1] |=> stat_r[1])
      else $error("byte cause flag not set");
   AST_FC_CAUSE: assert property (
      ce_in && isr_refresh_in && !(thr_en_r[0] && thr_bus.hit[0]) |=> !stat_r[0])
      else $error("frame cause flag set without cause");
   AST_CAUSE_HOLD: assert property (
      !(ce_in && isr_refresh_in) |=> $stable(stat_r))
      else $error("cause flags changed without refresh");
   AST_PAD_WRITE: assert property (
      ce_in && wr_hi |=> ip_align_pad_enable_out == $past(dat_q[rqc_pkg::BIT_IP_PAD]))
      else $error("pad enable not written");
   AST_DUR_IRQ: assert property (
      ce_in && thr_en_r[2] && thr_bus.hit[2] |=> rx_irq_out)
      else $error("dwell interrupt missing");
   AST_BC_IRQ: assert property (
      ce_in && thr_en_r[1] && thr_bus.hit[1] |=> rx_irq_out)
      else $error("byte interrupt missing");
   AST_NO_IRQ: assert property (
      ce_in && (thr_en_r & thr_bus.hit) == 3'h0 |=> !rx_irq_out)
      else $error("interrupt without enabled cause");
   AST_DEQUEUE: assert property (
      ce_in && frame_read_done_in |=> dequeue_pulse_out == $past(auto_dq_r))
      else $error("dequeue mismatch");
   AST_WINDOW_READ: assert property (
      s_window_read |=> rxq_read_pulse_out && !reg_read_pulse_out
      ##1 ce_in [*1] ##0 rd_src_r == rqc_pkg::SRC_RXQ)
      else $error("window read lost");
   AST_BLOCKED: assert property (
      ce_in && dma_active_out |=> !reg_write_pulse_out && !reg_read_pulse_out)
      else $error("register reached in window");
   AST_RELEASE: assert property (
      s_release_cycle |=> !rel_r && $past(rel_r, 1))
      else $error("release bit not self-cleared");
   AST_SET_WINS: assert property (
      ce_in && rel_set && release_done_in |=> rel_r && release_pulse_out)
      else $error("release request lost");
   AST_RSVD_ZERO: assert property (
      ce_in && rd_pend_r && rd_src_r == rqc_pkg::SRC_CMD |=>
      host_data_out[15:13] == 3'h0 && !host_data_out[8] && host_data_out[3:1] == 3'h0)
      else $error("reserved bits not zero");
endmodule : rqc_cmd

// >>> verif/rqc_host_model.sv
// Host processor model driving the parallel bus strobes
module rqc_host_model (
   input  wire logic        clk_in,      // Core clock
   input  wire logic [15:0] rd_data_in,  // Bus read data
   output logic             aen_n_out,   // Address strobe
   output logic             rd_n_out,    // Read strobe
   output logic             wr_n_out,    // Write strobe
   output logic [10:0]      addr_out,    // Byte address
   output logic [1:0]       be_n_out,    // Byte enables
   output logic [15:0]      data_out     // Write data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      aen_n_out = 1'h1;
      rd_n_out  = 1'h1;
      wr_n_out  = 1'h1;
      addr_out  = 11'h000;
      be_n_out  = 2'h3;
      data_out  = 16'h0000;
   end

   // Strobes held six cycles each way to outlast the two-flop sync
   task automatic wr(input logic [10:0] a, input logic [15:0] d, input logic [1:0] be);
      @(negedge clk_in);
      addr_out  = a;
      data_out  = d;
      be_n_out  = be;
      aen_n_out = 1'h0;
      @(negedge clk_in);
      wr_n_out = 1'h0;
      repeat (6) @(negedge clk_in);
      wr_n_out = 1'h1;
      repeat (6) @(negedge clk_in);
      aen_n_out = 1'h1;
      // Released bus shows inverted values, not stale ones
      addr_out = ~a;
      data_out = ~d;
      repeat (6) @(negedge clk_in);
   endtask : wr

   task automatic rd(input logic [10:0] a, output logic [15:0] d);
      @(negedge clk_in);
      addr_out  = a;
      be_n_out  = 2'h0;
      aen_n_out = 1'h0;
      // Address must settle a cycle ahead: the decode sees it three flops late
      @(negedge clk_in);
      rd_n_out  = 1'h0;
      repeat (8) @(negedge clk_in);
      d = rd_data_in;
      rd_n_out  = 1'h1;
      aen_n_out = 1'h1;
      repeat (2) @(negedge clk_in);
      addr_out  = ~a;
      repeat (4) @(negedge clk_in);
   endtask : rd
endmodule : rqc_host_model

// >>> verif/tb_rqc_cmd.sv
// Self-checking bench for the receive queue command block
module tb_rqc_cmd;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, aen_n, rd_n, wr_n, pad, dma, irq, dq, rel, rxqp, txqp, regrp, regwp, oe;
   logic        clk_en = 1'h1;
   logic [10:0] rega;
   logic [1:0]  regbe;
   logic [15:0] regwd;
   logic [15:0] regd = 16'hbeef;
   logic        rst_n = 1'h0;
   logic        refr = 1'h0;
   logic        frd = 1'h0;
   logic        reld = 1'h0;
   logic [10:0] addr;
   logic [1:0]  be_n;
   logic [15:0] wdata, rdat, txqd;
   logic [15:0] fc = 16'h0000;
   logic [15:0] bc = 16'h0000;
   logic [15:0] cf [3] = '{16'h0003, 16'h0000, 16'h0001};
   logic [15:0] cb [3] = '{16'h0000, 16'h00c8, 16'h0000};
   logic [15:0] ce [3] = '{16'h0400, 16'h0800, 16'h1000};
   int          cw [3] = '{10, 10, 60};
   int          miscompares = 0, comparisons = 0;
   int          n_rel = 0, n_rxq = 0, n_txq = 0, n_regr = 0, n_regw = 0, n_oe = 0;

   rqc_cmd #(.CNT_W(16)) u_dut (
      .core_clk_in(clk), .reset_n_in(rst_n), .ce_in(clk_en),
      .host_address_enable_strobe_n_in(aen_n), .host_read_strobe_n_in(rd_n),
      .host_write_strobe_n_in(wr_n), .host_addr_in(addr), .host_byte_en_n_in(be_n),
      .host_data_in(wdata), .rx_frame_count_in(fc), .rx_byte_count_in(bc),
      .duration_threshold_value_in(16'h0028), .byte_count_threshold_value_in(16'h0064),
      .frame_count_threshold_value_in(16'h0002), .isr_refresh_in(refr),
      .frame_read_done_in(frd), .release_done_in(reld), .rxq_read_data_in(16'h5a3c),
      .reg_read_data_in(regd), .host_data_out(rdat), .host_data_oe_out(oe),
      .ip_align_pad_enable_out(pad), .dma_active_out(dma), .rx_irq_out(irq),
      .dequeue_pulse_out(dq), .release_pulse_out(rel), .rxq_read_pulse_out(rxqp),
      .txq_write_pulse_out(txqp), .txq_write_data_out(txqd), .reg_read_pulse_out(regrp),
      .reg_write_pulse_out(regwp), .reg_addr_out(rega), .reg_write_data_out(regwd),
      .reg_byte_en_n_out(regbe));

   rqc_host_model u_host (.clk_in(clk), .rd_data_in(rdat), .aen_n_out(aen_n), .rd_n_out(rd_n),
      .wr_n_out(wr_n), .addr_out(addr), .be_n_out(be_n), .data_out(wdata));

   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rel === 1'h1) n_rel++;
      if (rxqp === 1'h1) n_rxq++;
      if (txqp === 1'h1) n_txq++;
      if (regrp === 1'h1) n_regr++;
      if (regwp === 1'h1) n_regw++;
      if (oe === 1'h1) n_oe++;
   end

   task automatic conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [15:0] got_v, input logic [15:0] exp_v);
      comparisons++;
      if (got_v !== exp_v) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask : check

   task automatic rdchk(input logic [10:0] a, input logic [15:0] e);
      logic [15:0] v;
      u_host.rd(a, v);
      check(v, e);
   endtask : rdchk

   task automatic pulse(ref logic s);
      s = 1'h1;
      @(negedge clk);
      s = 1'h0;
   endtask : pulse

   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      conclude();
   end

   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'h1;
      repeat (3) @(negedge clk);
      check(16'({pad, dma, irq, dq, rel}), 16'h0000);
      rdchk(11'h182, 16'h0000);
      u_host.wr(11'h182, 16'hfcf6, 2'h0);
      rdchk(11'h182, 16'h00f0);
      // Upper byte only: low byte must keep its enables
      u_host.wr(11'h182, 16'h0200, 2'h1);
      rdchk(11'h182, 16'h02f0);
      check(16'(pad), 16'h0001);
      for (int i = 0; i < 3; i++) begin
         fc = cf[i];
         bc = cb[i];
         repeat (cw[i]) @(negedge clk);
         check(16'(irq), 16'h0001);
         pulse(refr);
         rdchk(11'h182, 16'h02f0 | ce[i]);
         fc = 16'h0000;
         bc = 16'h0000;
         repeat (4) @(negedge clk);
      end
      // Enables off: a frame count over limit must stay silent
      u_host.wr(11'h182, 16'h0010, 2'h0);
      fc = 16'h0003;
      repeat (10) @(negedge clk);
      check(16'(irq), 16'h0000);
      pulse(refr);
      fc = 16'h0000;
      rdchk(11'h182, 16'h0010);
      pulse(frd);
      check(16'(dq), 16'h0001);
      // Frozen core must not take a dequeue request
      repeat (2) @(negedge clk);
      clk_en = 1'h0;
      pulse(frd);
      check(16'(dq), 16'h0000);
      clk_en = 1'h1;
      u_host.wr(11'h182, 16'h0011, 2'h0);
      rdchk(11'h182, 16'h0011);
      pulse(reld);
      rdchk(11'h182, 16'h0010);
      check(16'(n_rel), 16'h0001);
      // Request and completion together: the request must still be taken
      reld = 1'h1;
      u_host.wr(11'h182, 16'h0011, 2'h0);
      reld = 1'h0;
      rdchk(11'h182, 16'h0010);
      check(16'(n_rel), 16'h0002);
      u_host.wr(11'h186, 16'h4000, 2'h0);
      check({regbe, 3'h0, rega}, 16'h0186);
      check(regwd, 16'h4000);
      u_host.wr(11'h182, 16'h0018, 2'h0);
      check(16'(dma), 16'h0001);
      rdchk(11'h300, 16'h5a3c);
      u_host.wr(11'h010, 16'h1234, 2'h3);
      check(txqd, 16'h1234);
      rdchk(11'h182, 16'h0010);
      check({n_rxq[3:0], n_txq[3:0], n_regr[3:0], n_regw[3:0]}, 16'h1101);
      u_host.wr(11'h182, 16'h0010, 2'h0);
      check(16'(dma), 16'h0000);
      rdchk(11'h010, 16'hbeef);
      check({n_rxq[3:0], n_txq[3:0], n_regr[3:0], n_regw[3:0]}, 16'h1111);
      check(16'(rega), 16'h0010);
      // Thirteen reads, each driving the bus for eight cycles
      check(16'(n_oe), 16'h0068);
      conclude();
   end
endmodule : tb_rqc_cmd
